// ==== verilog/slr_regs.sv ====
// Strap summary and link/negotiation status registers.
// Assumes the register port and link inputs are synchronous to clk_sys_in.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module slr_regs (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Strap pins.
    input wire slr_pkg::slr_straps_t straps_in,
    // Live link state.
    input wire slr_pkg::slr_link_t link_in,
    input wire logic fifo_event_in,
    input wire logic shallow_loop_sel_in,
    input wire logic deep_loop_sel_in,
    // Register port.
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Defaults for control registers elsewhere.
    output logic neg_enable_default_out,
    output logic duplex_default_out,
    output logic [1:0] speed_default_out,
    output logic nonstd_default_out,
    output logic mac_clk_enable_out,
    output logic crossover_default_out,
    output logic multi_default_out,
    output logic [4:0] station_number_out
);
    import slr_pkg::*;

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ************************************************************
    // Strap capture
    // ************************************************************
    // Straps are sampled every clock while reset is held and frozen
    // once it is released; writes never reach them.
    slr_straps_t straps;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n) begin
            straps <= straps_in;
        end
    end

    logic [15:0] strap_word;
    always_comb begin
        strap_word = 16'h0000;
        strap_word[SLR_SS_NEG] = straps.negotiation_strap;
        strap_word[SLR_SS_DUPLEX] = straps.duplex;
        strap_word[SLR_SS_SPEED_LO +: 2] = straps.speed;
        strap_word[SLR_SS_NONSTD] = straps.nonstd;
        strap_word[SLR_SS_MACCLK] = straps.mac_clk;
        strap_word[SLR_SS_XOVER] = straps.auto_crossover_strap;
        strap_word[SLR_SS_MULTI] = straps.multi;
        strap_word[SLR_SS_STATION_LO +: 5] = straps.station_number;
    end

    assign neg_enable_default_out = straps.negotiation_strap;
    assign duplex_default_out = straps.duplex;
    assign speed_default_out = straps.speed;
    assign nonstd_default_out = straps.nonstd;
    assign mac_clk_enable_out = straps.mac_clk;
    assign crossover_default_out = straps.auto_crossover_strap;
    assign multi_default_out = straps.multi;
    assign station_number_out = straps.station_number;

    // ************************************************************
    // Sticky transmit FIFO error
    // ************************************************************
    // A new error wins over link loss in the same cycle.
    logic fifo_fault;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            fifo_fault <= 1'b0;
        end else if (fifo_event_in) begin
            fifo_fault <= 1'b1;
        end else if (!link_in.link_good) begin
            fifo_fault <= 1'b0;
        end
    end

    // ************************************************************
    // Status word
    // ************************************************************
    logic [15:0] status_word;
    always_comb begin
        status_word = 16'h0000;
        status_word[SLR_ST_POL_LO +: 4] = link_in.pair_polarity_flags;
        status_word[SLR_ST_PWRDN] = link_in.power_down;
        status_word[SLR_ST_XOVER] = link_in.crossover;
        status_word[SLR_ST_FIFO] = fifo_fault;
        status_word[SLR_ST_SHALLOW] = shallow_loop_sel_in;
        status_word[SLR_ST_DEEP] = deep_loop_sel_in;
        status_word[SLR_ST_NONSTD] = link_in.nonstd_only;
        status_word[SLR_ST_LINK] = link_in.link_good;
        status_word[SLR_ST_DUPLEX] = link_in.full_duplex;
        status_word[SLR_ST_MASTER] = link_in.master;
        // Until a link resolves a speed, the strapped speed is shown.
        if (link_in.link_good) begin
            status_word[SLR_ST_SPEED_LO +: 2] = link_in.speed;
        end else begin
            status_word[SLR_ST_SPEED_LO +: 2] = straps.speed;
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    // Both registers are read-only; writes and write data are ignored.
    logic unused_wr;
    assign unused_wr = reg_wr_in ^ (^reg_wdata_in);

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= SLR_RST_STATUS;
        end else if (reg_rd_in) begin
            if (reg_addr_in == SLR_ADDR_STRAP) begin
                reg_rdata_out <= strap_word;
            end else if (reg_addr_in == SLR_ADDR_STATUS) begin
                reg_rdata_out <= status_word;
            end else begin
                reg_rdata_out <= 16'h0000;
            end
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule : slr_regs

// ==== verilog/slr_pkg.sv ====
// Package for the strap summary and link status register block.
// Assumes a single 100 MHz core clock and a plain register port.
// Operation
// - Bit 15 latches negotiation strap, seeds control bit 12.
// - Bit 14 latches duplex strap, seeds control bit 8.
// - Bits 13:12 latch speed straps, seed speed bits.
// - Bit 10 latches nonstandard strap, seeds aux bit 9.
// - Bit 7 reports MAC clock output strap.
// - Bit 6 latches crossover strap, seeds aux bit 15.
// - Bit 5 latches multi-port strap, seeds bit 10.
// - Bits 4:0 latch station number, seed 0x01 default.
// - Strap bits read-only, change only at reset.
// - Bits 15:12 flag reversed polarity, pairs A to D.
// - Bit 11 set while powered down.
// - Bit 10 reports crossover versus straight mapping.
// - Bit 9 sticky FIFO error, cleared on link loss.
// - Bit 7 reports shallow loopback active.
// - Bit 6 reports deep loopback active.
// - Bit 5 reports nonstandard-only detection.
// - Bits 4:3 report resolved speed, strap default.
// - Bit 2 reports good link.
// - Bit 1 reports full duplex.
// - Bit 0 reports clock master role.
package slr_pkg;

    localparam logic [4:0] SLR_ADDR_STRAP = 5'h10;
    localparam logic [4:0] SLR_ADDR_STATUS = 5'h11;

    // Strap summary field positions.
    localparam int SLR_SS_NEG = 15;
    localparam int SLR_SS_DUPLEX = 14;
    localparam int SLR_SS_SPEED_LO = 12;
    localparam int SLR_SS_NONSTD = 10;
    localparam int SLR_SS_MACCLK = 7;
    localparam int SLR_SS_XOVER = 6;
    localparam int SLR_SS_MULTI = 5;
    localparam int SLR_SS_STATION_LO = 0;

    // Status field positions.
    localparam int SLR_ST_POL_LO = 12;
    localparam int SLR_ST_PWRDN = 11;
    localparam int SLR_ST_XOVER = 10;
    localparam int SLR_ST_FIFO = 9;
    localparam int SLR_ST_SHALLOW = 7;
    localparam int SLR_ST_DEEP = 6;
    localparam int SLR_ST_NONSTD = 5;
    localparam int SLR_ST_SPEED_LO = 3;
    localparam int SLR_ST_LINK = 2;
    localparam int SLR_ST_DUPLEX = 1;
    localparam int SLR_ST_MASTER = 0;

    // Strap reset values; slr_regs never loads them, as the strap register has no reset.
    localparam logic SLR_RST_NEG = 1'h1;
    localparam logic SLR_RST_DUPLEX = 1'h1;
    localparam logic [1:0] SLR_RST_SPEED = 2'h0;
    localparam logic SLR_RST_NONSTD = 1'h0;
    localparam logic SLR_RST_MACCLK = 1'h1;
    localparam logic SLR_RST_XOVER = 1'h1;
    localparam logic SLR_RST_MULTI = 1'h0;
    localparam logic [4:0] SLR_RST_STATION = 5'h01;

    localparam logic [15:0] SLR_RST_STATUS = 16'h0000;

    // Captured strap values.
    typedef struct packed {
        logic negotiation_strap;
        logic duplex;
        logic [1:0] speed;
        logic nonstd;
        logic mac_clk;
        logic auto_crossover_strap;
        logic multi;
        logic [4:0] station_number;
    } slr_straps_t;

    // Live state for the link status register; its fifo_fault field is not reported.
    typedef struct packed {
        logic [3:0] pair_polarity_flags;
        logic power_down;
        logic crossover;
        logic fifo_fault;
        logic link_good;
        logic nonstd_only;
        logic [1:0] speed;
        logic full_duplex;
        logic master;
    } slr_link_t;

endpackage : slr_pkg

// ==== tb/slr_chk.sv ====
// Checker for the strap summary and link status register port.
// Bound to slr_regs; sees its ports only, one clock domain.
`timescale 1ns/1ns
module slr_chk (
    // Clock, reset, inputs.
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire slr_pkg::slr_link_t link_in,
    input wire logic fifo_event_in,
    input wire logic shallow_loop_sel_in,
    input wire logic deep_loop_sel_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_rd_in,
    // Outputs.
    input wire logic [15:0] reg_rdata_out,
    input wire logic neg_enable_default_out,
    input wire logic duplex_default_out,
    input wire logic [1:0] speed_default_out,
    input wire logic nonstd_default_out,
    input wire logic mac_clk_enable_out,
    input wire logic crossover_default_out,
    input wire logic multi_default_out,
    input wire logic [4:0] station_number_out
);
    import slr_pkg::*;
    logic [15:0] ss;
    slr_link_t lp;
    logic [1:0] ls;
    assign ss = {neg_enable_default_out, duplex_default_out, speed_default_out, 1'b0, nonstd_default_out,
        2'b00, mac_clk_enable_out, crossover_default_out, multi_default_out, station_number_out};
    always_ff @(posedge clk_sys_in) begin
        lp <= link_in;
        ls <= {shallow_loop_sel_in, deep_loop_sel_in};
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_st;
        reg_rd_in && reg_addr_in == SLR_ADDR_STATUS;
    endsequence
    sequence s_ss;
        reg_rd_in && reg_addr_in == SLR_ADDR_STRAP;
    endsequence
    AST_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000) else $error("read data not idle");
    AST_SS: assert property (s_ss |=> reg_rdata_out == ss)
        else $error("strap word wrong");
    AST_HOLD: assert property (arst_n_in && $past(arst_n_in, 3) |-> $stable(ss))
        else $error("strap changed");
    AST_POL: assert property (s_st |=> reg_rdata_out[15:12] == lp.pair_polarity_flags)
        else $error("polarity wrong");
    AST_PWX: assert property (s_st |=> reg_rdata_out[11:10] == {lp.power_down, lp.crossover})
        else $error("power or crossover wrong");
    AST_FIFO: assert property (fifo_event_in ##1 s_st |=> reg_rdata_out[9])
        else $error("fifo error not set");
    AST_LOOP: assert property (s_st |=> reg_rdata_out[7:6] == ls)
        else $error("loopback wrong");
    AST_SPD: assert property (s_st |=> reg_rdata_out[5:3] ==
        {lp.nonstd_only, lp.link_good ? lp.speed : speed_default_out}) else $error("speed wrong");
    AST_LNK: assert property (s_st |=> reg_rdata_out[2:0] ==
        {lp.link_good, lp.full_duplex, lp.master}) else $error("link bits wrong");
endmodule : slr_chk
bind slr_regs slr_chk u_chk (.*);

// ==== tb/slr_mgmt.sv ====
// Station management controller model for the register port.
// Tasks are called by the bench; one clock.
`timescale 1ns/1ns
module slr_mgmt (
    // Clock.
    input wire logic clk_sys_in,
    // Register port.
    output logic [4:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [15:0] reg_rdata_in
);
    initial begin
        reg_addr_out = 5'h00;
        reg_wdata_out = 16'h0000;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_wdata_out <= d & 16'hf4ff;
        reg_wr_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        reg_wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        @(posedge clk_sys_in);
        d = reg_rdata_in;
    endtask : rd
endmodule : slr_mgmt

// ==== tb/tb_strap_and_link_status_regs.sv ====
// Bench for the strap summary and link status registers.
// Drives straps and link state; the model does register accesses.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t %h", $time, a); end end
module tb_strap_and_link_status_regs;
    import slr_pkg::*;
    logic clk_sys_in;
    logic arst_n_in;
    logic fifo_ev;
    logic wr;
    logic rd;
    logic [1:0] ls;
    logic [4:0] addr;
    logic [15:0] wd;
    logic [15:0] rdat;
    logic [15:0] d;
    slr_straps_t st;
    slr_straps_t so;
    slr_straps_t sa;
    slr_straps_t sx;
    slr_link_t lk;
    slr_link_t la;
    int err_count;
    int tests_run;
    slr_mgmt u_mgmt (.clk_sys_in(clk_sys_in), .reg_addr_out(addr), .reg_wdata_out(wd), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_rdata_in(rdat));
    slr_regs u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .straps_in(st), .link_in(lk),
        .fifo_event_in(fifo_ev), .shallow_loop_sel_in(ls[1]), .deep_loop_sel_in(ls[0]),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .neg_enable_default_out(so.negotiation_strap), .duplex_default_out(so.duplex),
        .speed_default_out(so.speed), .nonstd_default_out(so.nonstd), .mac_clk_enable_out(so.mac_clk),
        .crossover_default_out(so.auto_crossover_strap), .multi_default_out(so.multi),
        .station_number_out(so.station_number));
    function automatic logic [15:0] ssw(slr_straps_t s);
        return {s.negotiation_strap, s.duplex, s.speed, 1'b0, s.nonstd, 2'b00, s.mac_clk,
            s.auto_crossover_strap, s.multi, s.station_number};
    endfunction : ssw
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        arst_n_in = 1'b0;
        fifo_ev = 1'b0;
        ls = 2'b00;
        lk = '0;
        err_count = 0;
        tests_run = 0;
        sa = '{negotiation_strap: 0, duplex: 1, speed: 2'h2, nonstd: 1, mac_clk: 0,
            auto_crossover_strap: 0, multi: 1, station_number: 5'h16};
        la = '{pair_polarity_flags: 4'h9, power_down: 1, crossover: 0, fifo_fault: 0, link_good: 1,
            nonstd_only: 1, speed: 2'h1, full_duplex: 0, master: 1};
        st = sa;
        for (int r = 0; r < 2; r++) begin
            sx = r ? ~sa : sa;
            @(posedge clk_sys_in);
            arst_n_in <= 1'b0;
            st <= sx;
            repeat (4) @(posedge clk_sys_in);
            arst_n_in <= 1'b1;
            repeat (4) @(posedge clk_sys_in);
            st <= ~sx;
            u_mgmt.wr(SLR_ADDR_STRAP, ssw(~sx));
            u_mgmt.rd(SLR_ADDR_STRAP, d);
            `CHK(d, ssw(sx))
            `CHK(so, sx)
        end
        u_mgmt.rd(5'h05, d);
        `CHK(d, 16'h0000)
        $display("test straps done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_in);
            lk <= i[0] ? ~la : la;
            ls <= i[1:0];
            u_mgmt.rd(SLR_ADDR_STATUS, d);
            `CHK(d, {lk.pair_polarity_flags, lk.power_down, lk.crossover, 2'b00, ls, lk.nonstd_only,
                lk.link_good ? lk.speed : sx.speed, lk.link_good, lk.full_duplex, lk.master})
        end
        $display("test status done");
        @(posedge clk_sys_in);
        lk <= la;
        fifo_ev <= 1'b1;
        fork
            u_mgmt.rd(SLR_ADDR_STATUS, d);
            @(posedge clk_sys_in) fifo_ev <= 1'b0;
        join
        `CHK(d[9], 1'b1)
        u_mgmt.rd(SLR_ADDR_STATUS, d);
        `CHK(d[9], 1'b1)
        lk.link_good <= 1'b0;
        @(posedge clk_sys_in);
        lk.link_good <= 1'b1;
        u_mgmt.rd(SLR_ADDR_STATUS, d);
        `CHK(d[9], 1'b0)
        $display("test fifo done");
        summarize();
    end
endmodule : tb_strap_and_link_status_regs
